// File: rtl/tlo_cfg.svh
// Constants of the temperature lookup and output configuration block
`ifndef TLO_CFG_SVH
`define TLO_CFG_SVH

`define TLO_IDX_INDEX     10'h081
`define TLO_IDX_SWING     10'h082
`define TLO_IDX_AUX_A     10'h084
`define TLO_IDX_AUX_B     10'h086
`define TLO_IDX_RATE      10'h088
`define TLO_IDX_CONFIG    10'h089

`define TLO_INDEX_RST     8'h00
`define TLO_CODE_RST      10'h000
`define TLO_RATE_RST      8'h00
`define TLO_CONFIG_RST    8'h80
`define TLO_CONFIG_MASK   8'hbc

`define TLO_CFG_SRC_BIT   7
`define TLO_CFG_INV_BIT   5
`define TLO_CFG_BUS_ADDRESS_SELECT_BIT  4
`define TLO_CFG_ROW_BIT   3
`define TLO_CFG_RSEL_BIT  2
`define TLO_RATE_MSB      3

`define TLO_FIXED_ADDR    8'ha2
`define TLO_INDEX_BASE    8'h80
`define TLO_INDEX_TOP     8'hc7
`define TLO_TEMP_LOW      16'hd800
`define TLO_TEMP_HIGH     16'h6600
`define TLO_TEMP_SHIFT    17'h02800
`define TLO_INDEX_DIV_SH  9
`define TLO_BYTE_FIRST    8'hf8
`define TLO_BYTE_LAST     8'hff

`define TLO_CLK_NS        4
`define TLO_WINDOW_NS     1600
`define TLO_SETTLE_NS     51200
`define TLO_SETTLE_SAMPS  32
`define TLO_SAMPLE_NS     (`TLO_SETTLE_NS / `TLO_SETTLE_SAMPS)

`endif

// File: rtl/tlo_pkg.sv
// Types shared by the temperature lookup and output configuration block
package tlo_pkg;
	typedef enum logic [0:0] {
		TLO_LOOP_RUN,
		TLO_LOOP_SETTLE
	} tlo_loop_state_t;
endpackage

// File: rtl/tlo_index_calc.sv
// Temperature to lookup index conversion with clamping
`include "tlo_cfg.svh"

module tlo_index_calc (
	// Measured temperature, signed, 1/256 degree units
	input  wire logic [15:0] temp_value_i,
	// Computed index
	output logic      [7:0]  index_o
);
	logic signed [16:0] shifted;
	logic signed [16:0] halved;

	always_comb begin
		shifted = $signed({temp_value_i[15], temp_value_i}) + $signed(`TLO_TEMP_SHIFT);
		halved  = shifted >>> `TLO_INDEX_DIV_SH;
		if ($signed(temp_value_i) < $signed(`TLO_TEMP_LOW)) begin
			index_o = `TLO_INDEX_BASE;
		end else if ($signed(temp_value_i) > $signed(`TLO_TEMP_HIGH)) begin
			index_o = `TLO_INDEX_TOP;
		end else begin
			index_o = halved[7:0] + `TLO_INDEX_BASE;
		end
	end
endmodule

// File: rtl/tlo_settle_timer.sv
// Power-loop sample timing, settling hold-off and fast-trip window
`include "tlo_cfg.svh"

module tlo_settle_timer (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Control
	input  wire logic [3:0] sample_rate_i,
	input  wire logic       bias_update_i,
	// Timing outputs
	output logic            window_o,
	output logic            sample_o,
	output logic            compare_en_o
);
	localparam int TICK_CYC = `TLO_SAMPLE_NS / `TLO_CLK_NS;
	localparam int WIN_CYC  = `TLO_WINDOW_NS / `TLO_CLK_NS;

	logic [8:0]               tick_reg;
	logic [8:0]               win_gap_reg;
	logic [3:0]               rate_cnt_reg;
	logic [5:0]               samp_cnt_reg;
	logic                     tick;
	logic                     sample;
	tlo_pkg::tlo_loop_state_t state_reg;

	assign tick   = (tick_reg == 9'(TICK_CYC - 1));
	// Greater-or-equal so a lowered rate never stalls the count
	assign sample = tick && (rate_cnt_reg >= sample_rate_i);

	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			tick_reg <= 9'h000;
		end else begin
			tick_reg <= tick_reg + 9'h001;
		end
	end

	// One sample period is rate plus one base windows
	always_ff @(posedge clk_i) begin
		if (rst_i || sample) begin
			rate_cnt_reg <= 4'h0;
		end else if (tick) begin
			rate_cnt_reg <= rate_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg    <= tlo_pkg::TLO_LOOP_RUN;
			samp_cnt_reg <= 6'h00;
		end else begin
			unique case (state_reg)
				tlo_pkg::TLO_LOOP_RUN: begin
					samp_cnt_reg <= 6'h00;
					if (bias_update_i) begin
						state_reg <= tlo_pkg::TLO_LOOP_SETTLE;
					end
				end
				tlo_pkg::TLO_LOOP_SETTLE: begin
					if (sample) begin
						samp_cnt_reg <= samp_cnt_reg + 6'h01;
						if (samp_cnt_reg == 6'(`TLO_SETTLE_SAMPS - 1)) begin
							state_reg <= tlo_pkg::TLO_LOOP_RUN;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			window_o     <= 1'b0;
			sample_o     <= 1'b0;
			compare_en_o <= 1'b1;
		end else begin
			window_o     <= tick;
			sample_o     <= sample;
			compare_en_o <= (state_reg == tlo_pkg::TLO_LOOP_RUN) && !bias_update_i;
		end
	end

	// Cycles since the last window; all ones so the first window counts alike
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			win_gap_reg <= '1;
		end else if (window_o) begin
			win_gap_reg <= 9'h000;
		end else begin
			win_gap_reg <= win_gap_reg + 9'h001;
		end
	end

	window_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
		window_o == (win_gap_reg == 9'(WIN_CYC - 1)))
		else $error("fast-trip window period wrong");

	settle_holds_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_reg == tlo_pkg::TLO_LOOP_SETTLE && samp_cnt_reg < 6'(`TLO_SETTLE_SAMPS))
		|-> ##1 !compare_en_o)
		else $error("comparison enabled while settling");
endmodule

// File: rtl/tlo_top.sv
// Temperature index, lookup addressing, output codes and pin configuration
//
// The implementer's own choice: register access over Wishbone.
`include "tlo_cfg.svh"

module tlo_top #(
	parameter int ENTRY_W = 8,
	parameter int CODE_W  = 10
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [11:2]       wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// Security levels and permissions
	input  wire logic              high_password_level_i,
	input  wire logic              low_password_level_i,
	input  wire logic              table_two_write_perm_i,
	input  wire logic              table_two_read_perm_i,
	input  wire logic              combined_table_write_perm_i,
	input  wire logic              combined_table_read_perm_i,
	// Mode controls
	input  wire logic              auto_index_enable_i,
	input  wire logic              swing_lut_enable_i,
	input  wire logic              aux_a_lut_enable_i,
	input  wire logic              aux_b_lut_enable_i,
	// Conversion and bus events
	input  wire logic [15:0]       temp_value_i,
	input  wire logic              temp_conv_done_i,
	input  wire logic              bus_stop_i,
	// Lookup table interface
	output logic      [7:0]        swing_lut_addr_o,
	output logic      [7:0]        aux_a_lut_addr_o,
	output logic      [7:0]        power_loop_lut_addr_o,
	output logic      [7:0]        aux_b_lut_addr_o,
	output logic      [7:0]        eight_entry_byte_o,
	input  wire logic [ENTRY_W-1:0] swing_table_entry_i,
	input  wire logic [ENTRY_W-1:0] aux_a_table_entry_i,
	input  wire logic [ENTRY_W-1:0] aux_b_table_entry_i,
	input  wire logic [7:0]        swing_offset_i,
	input  wire logic [7:0]        aux_a_offset_i,
	input  wire logic [7:0]        aux_b_offset_i,
	// Output codes
	output logic      [CODE_W-1:0] swing_code_o,
	output logic      [CODE_W-1:0] aux_a_code_o,
	output logic      [CODE_W-1:0] aux_b_code_o,
	// Power loop timing
	input  wire logic              bias_update_i,
	output logic                   back_monitor_compare_en_o,
	output logic                   power_loop_sample_o,
	output logic                   quick_trip_window_o,
	// Pins and address
	input  wire logic              signal_loss_in_i,
	input  wire logic              signal_loss_low_alarm_i,
	input  wire logic              rate_select_src_i,
	input  wire logic [7:0]        device_address_i,
	output logic                   signal_loss_out_o,
	output logic                   rate_select_out_o,
	output logic      [7:0]        bus_address_o,
	output logic                   alarm_row_table5_o
);
	localparam int NCH = 3;

	logic [7:0]        temp_lut_index_reg;
	logic [7:0]        loop_update_rate_reg;
	logic [7:0]        pin_and_address_config_reg;
	logic [7:0]        calc_index;
	logic [1:0]        reload_pipe_reg;
	logic              los_meta_reg;
	logic              los_sync_reg;
	logic              req;
	logic              wr;
	logic              pw_t2_read;
	logic              pw_t2_write;
	logic              pw_comb_read;
	logic              pw_comb_write;
	logic              addr_hit;
	logic [31:0]       rdata;
	logic [2:0]        byte_step;
	logic [NCH-1:0]        lut_en;
	logic [NCH-1:0]        ch_hit;
	logic [NCH-1:0]        ch_wr_ok;
	logic [NCH-1:0]        ch_rd_ok;
	logic [ENTRY_W-1:0]    entry   [NCH];
	logic [7:0]            offset  [NCH];
	logic [CODE_W-1:0]     code_reg [NCH];
	logic [CODE_W-1:0]     out_reg  [NCH];

	// Access qualifiers from the security block, no pipelining
	assign pw_t2_read    = high_password_level_i ||
		(low_password_level_i && (table_two_write_perm_i || table_two_read_perm_i));
	assign pw_t2_write   = high_password_level_i ||
		(low_password_level_i && table_two_write_perm_i);
	assign pw_comb_read  = high_password_level_i ||
		(low_password_level_i && (combined_table_write_perm_i ||
		combined_table_read_perm_i));
	assign pw_comb_write = high_password_level_i ||
		(low_password_level_i && combined_table_write_perm_i);

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr  = req && wb_we_i;

	assign lut_en   = {aux_b_lut_enable_i, aux_a_lut_enable_i, swing_lut_enable_i};
	assign ch_hit   = {wb_adr_i == `TLO_IDX_AUX_B, wb_adr_i == `TLO_IDX_AUX_A,
		wb_adr_i == `TLO_IDX_SWING};
	assign ch_wr_ok = {pw_comb_write, pw_comb_write, pw_t2_write} & ~lut_en;
	assign ch_rd_ok = {pw_comb_read, pw_comb_read, pw_t2_read};
	assign entry[0]  = swing_table_entry_i;
	assign entry[1]  = aux_a_table_entry_i;
	assign entry[2]  = aux_b_table_entry_i;
	assign offset[0] = swing_offset_i;
	assign offset[1] = aux_a_offset_i;
	assign offset[2] = aux_b_offset_i;

	tlo_index_calc u_index (
		.temp_value_i (temp_value_i),
		.index_o      (calc_index)
	);

	tlo_settle_timer u_settle (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.sample_rate_i (loop_update_rate_reg[`TLO_RATE_MSB:0]),
		.bias_update_i (bias_update_i),
		.window_o      (quick_trip_window_o),
		.sample_o      (power_loop_sample_o),
		.compare_en_o  (back_monitor_compare_en_o)
	);

	// Wishbone handshake: one wait state, ack for one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req) begin
			wb_dat_o <= wb_we_i ? 32'h0000_0000 : rdata;
		end
	end

	// Unmapped or refused reads return zero
	always_comb begin
		rdata    = 32'h0000_0000;
		addr_hit = 1'b0;
		unique case (wb_adr_i)
			`TLO_IDX_INDEX: begin
				addr_hit = 1'b1;
				if (pw_t2_read) begin
					rdata[7:0] = temp_lut_index_reg;
				end
			end
			`TLO_IDX_SWING, `TLO_IDX_AUX_A, `TLO_IDX_AUX_B: begin
				addr_hit = 1'b1;
				for (int i = 0; i < NCH; i++) begin
					if (ch_hit[i] && ch_rd_ok[i]) begin
						rdata[CODE_W-1:0] = code_reg[i];
					end
				end
			end
			`TLO_IDX_RATE: begin
				addr_hit = 1'b1;
				if (pw_t2_read) begin
					rdata[7:0] = loop_update_rate_reg;
				end
			end
			`TLO_IDX_CONFIG: begin
				addr_hit = 1'b1;
				if (pw_t2_read) begin
					rdata[7:0] = pin_and_address_config_reg;
				end
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
	end

	// Index follows each conversion only under automatic indexing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			temp_lut_index_reg <= `TLO_INDEX_RST;
		end else if (temp_conv_done_i && auto_index_enable_i) begin
			temp_lut_index_reg <= calc_index;
		end else if (wr && wb_adr_i == `TLO_IDX_INDEX && wb_sel_i[0] &&
			!auto_index_enable_i && pw_t2_write) begin
			temp_lut_index_reg <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loop_update_rate_reg <= `TLO_RATE_RST;
		end else if (wr && wb_adr_i == `TLO_IDX_RATE && wb_sel_i[0] && pw_t2_write) begin
			loop_update_rate_reg <= wb_dat_i[7:0];
		end
	end

	// Reserved config bits are not stored and read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_and_address_config_reg <= `TLO_CONFIG_RST;
		end else if (wr && wb_adr_i == `TLO_IDX_CONFIG && wb_sel_i[0] && pw_t2_write) begin
			pin_and_address_config_reg <= wb_dat_i[7:0] & `TLO_CONFIG_MASK;
		end
	end

	// Two-cycle wait lets the index and table addresses settle before reload
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reload_pipe_reg <= 2'b00;
		end else begin
			reload_pipe_reg <= {reload_pipe_reg[0], temp_conv_done_i};
		end
	end

	// Table addresses derived from the held index
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			swing_lut_addr_o      <= `TLO_INDEX_BASE;
			aux_a_lut_addr_o      <= `TLO_INDEX_BASE;
			power_loop_lut_addr_o <= `TLO_INDEX_BASE;
			aux_b_lut_addr_o      <= `TLO_INDEX_BASE;
		end else begin
			swing_lut_addr_o      <= {1'b1, temp_lut_index_reg[6:0]};
			aux_a_lut_addr_o      <= {1'b1, temp_lut_index_reg[6:0]};
			power_loop_lut_addr_o <= {2'b10, temp_lut_index_reg[6:1]};
			aux_b_lut_addr_o      <= {2'b10, temp_lut_index_reg[6:1]};
		end
	end

	// Eight-entry row: 10000 and 10001 share the first byte
	assign byte_step = (temp_lut_index_reg[5:3] < 3'h2) ? 3'h0 :
		temp_lut_index_reg[5:3] - 3'h1;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			eight_entry_byte_o <= `TLO_BYTE_FIRST;
		end else if (temp_lut_index_reg[7:6] == 2'b11) begin
			eight_entry_byte_o <= `TLO_BYTE_LAST;
		end else if (!temp_lut_index_reg[7]) begin
			eight_entry_byte_o <= `TLO_BYTE_FIRST;
		end else begin
			eight_entry_byte_o <= `TLO_BYTE_FIRST + {5'h00, byte_step};
		end
	end

	// Per-output code register and applied output value
	for (genvar g = 0; g < NCH; g++) begin : g_code
		logic [CODE_W-1:0] sum_next;

		assign sum_next = CODE_W'(entry[g]) + CODE_W'({offset[g], 2'b00});

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				code_reg[g] <= `TLO_CODE_RST;
			end else if (reload_pipe_reg[1] && lut_en[g]) begin
				code_reg[g] <= sum_next;
			end else if (wr && ch_hit[g] && ch_wr_ok[g]) begin
				if (wb_sel_i[1]) begin
					code_reg[g][CODE_W-1:8] <= wb_dat_i[CODE_W-1:8];
				end
				if (wb_sel_i[0]) begin
					code_reg[g][7:0] <= wb_dat_i[7:0];
				end
			end
		end

		// Manual writes reach the output only when the bus transfer ends
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				out_reg[g] <= `TLO_CODE_RST;
			end else if (reload_pipe_reg[1] && lut_en[g]) begin
				out_reg[g] <= sum_next;
			end else if (bus_stop_i && !lut_en[g]) begin
				out_reg[g] <= code_reg[g];
			end
		end
	end

	assign swing_code_o = out_reg[0];
	assign aux_a_code_o = out_reg[1];
	assign aux_b_code_o = out_reg[2];

	// Pin input crossing; first stage read only by the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			los_meta_reg <= 1'b0;
			los_sync_reg <= 1'b0;
		end else begin
			los_meta_reg <= signal_loss_in_i;
			los_sync_reg <= los_meta_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			signal_loss_out_o  <= 1'b0;
			rate_select_out_o  <= 1'b0;
			bus_address_o      <= `TLO_FIXED_ADDR;
			alarm_row_table5_o <= 1'b0;
		end else begin
			signal_loss_out_o  <= pin_and_address_config_reg[`TLO_CFG_SRC_BIT] ?
				(los_sync_reg ^ pin_and_address_config_reg[`TLO_CFG_INV_BIT]) :
				signal_loss_low_alarm_i;
			rate_select_out_o  <= rate_select_src_i ^
				pin_and_address_config_reg[`TLO_CFG_RSEL_BIT];
			bus_address_o      <= pin_and_address_config_reg[`TLO_CFG_BUS_ADDRESS_SELECT_BIT] ?
				device_address_i : `TLO_FIXED_ADDR;
			alarm_row_table5_o <= pin_and_address_config_reg[`TLO_CFG_ROW_BIT];
		end
	end

	ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	index_write_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && wb_adr_i == `TLO_IDX_INDEX && auto_index_enable_i && !temp_conv_done_i)
		|=> $stable(temp_lut_index_reg))
		else $error("index written under automatic indexing");

	index_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(temp_conv_done_i && auto_index_enable_i)
		|=> temp_lut_index_reg >= `TLO_INDEX_BASE && temp_lut_index_reg <= `TLO_INDEX_TOP)
		else $error("computed index out of clamp range");

	addr_layout_a: assert property (@(posedge clk_i) disable iff (rst_i)
		##1 power_loop_lut_addr_o == {2'b10, $past(temp_lut_index_reg[6:1])} &&
		swing_lut_addr_o == {1'b1, $past(temp_lut_index_reg[6:0])})
		else $error("table address layout wrong");

	top_byte_a: assert property (@(posedge clk_i) disable iff (rst_i)
		temp_lut_index_reg[7:6] == 2'b11 |=> eight_entry_byte_o == `TLO_BYTE_LAST)
		else $error("top eight-entry byte not selected");

	swing_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(temp_conv_done_i && swing_lut_enable_i) ##2 swing_lut_enable_i
		|=> swing_code_o == $past(g_code[0].sum_next))
		else $error("swing code not reloaded after conversion");

	swing_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(swing_lut_enable_i && !reload_pipe_reg[1]) |=> $stable(code_reg[0]))
		else $error("swing code changed under table control");

	aux_read_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && ch_hit[1] && !pw_comb_read) |=> wb_dat_o == 32'h0000_0000)
		else $error("aux code read without permission");

	stop_apply_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(bus_stop_i && !aux_b_lut_enable_i && !reload_pipe_reg[1])
		|=> aux_b_code_o == $past(code_reg[2]))
		else $error("aux B output not applied at stop");

	address_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!pin_and_address_config_reg[`TLO_CFG_BUS_ADDRESS_SELECT_BIT] |=> bus_address_o == `TLO_FIXED_ADDR)
		else $error("fixed bus address not used");

	unmapped_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !addr_hit) |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
		else $error("unmapped access answered wrongly");
endmodule

// File: tb/tlo_top_tb.sv
// Self-checking bench for the temperature lookup and output configuration block
`include "tlo_cfg.svh"

module tlo_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_i, rst_i, cyc, stb, we, hpw, lpw, t2w, t2r, cw, cr;
	logic        auto_index_enable, sen, aaen, ben, done, stop, bias, sl_in, sl_alm, rs_src;
	logic        cmp_en, smp, qtw, sl_out, rs_out, row5, ack;
	logic [9:0]  adr, c_sw, c_a, c_b;
	logic [3:0]  sel;
	logic [31:0] dat, dat_o;
	logic [15:0] temp;
	logic [7:0]  e_sw, e_a, e_b, o_sw, o_a, o_b, dev, i, v;
	logic [7:0]  a_sw, a_a, a_pl, a_b, byt, bus_adr;
	logic [31:0] exq[$];
	int          err_total, n_tests, seed, k, t, qn, sn, q0, s0;

	tlo_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .high_password_level_i(hpw), .low_password_level_i(lpw),
		.table_two_write_perm_i(t2w), .table_two_read_perm_i(t2r),
		.combined_table_write_perm_i(cw), .combined_table_read_perm_i(cr),
		.auto_index_enable_i(auto_index_enable), .swing_lut_enable_i(sen), .aux_a_lut_enable_i(aaen),
		.aux_b_lut_enable_i(ben), .temp_value_i(temp), .temp_conv_done_i(done),
		.bus_stop_i(stop), .swing_lut_addr_o(a_sw), .aux_a_lut_addr_o(a_a),
		.power_loop_lut_addr_o(a_pl), .aux_b_lut_addr_o(a_b), .eight_entry_byte_o(byt),
		.swing_table_entry_i(e_sw), .aux_a_table_entry_i(e_a), .aux_b_table_entry_i(e_b),
		.swing_offset_i(o_sw), .aux_a_offset_i(o_a), .aux_b_offset_i(o_b),
		.swing_code_o(c_sw), .aux_a_code_o(c_a), .aux_b_code_o(c_b),
		.bias_update_i(bias), .back_monitor_compare_en_o(cmp_en),
		.power_loop_sample_o(smp), .quick_trip_window_o(qtw), .signal_loss_in_i(sl_in),
		.signal_loss_low_alarm_i(sl_alm), .rate_select_src_i(rs_src),
		.device_address_i(dev), .signal_loss_out_o(sl_out), .rate_select_out_o(rs_out),
		.bus_address_o(bus_adr), .alarm_row_table5_o(row5));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %0t: got %h expected %h", $time, s, e);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Classic cycle; every answer, writes too, is noted for the watcher
	task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d,
			input logic [31:0] e);
		exq.push_back(e);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		sel <= 4'h3;
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	always @(posedge clk_i) begin
		if (ack === 1'b1) begin
			if (exq.size() == 0)
				chk(32'hdead_beef, 32'h0);
			else
				chk(dat_o, exq.pop_front());
		end
	end

	always @(posedge clk_i) begin
		if (qtw === 1'b1) qn++;
		if (smp === 1'b1) sn++;
	end

	initial begin
		#200000;
		err_total++;
		give_verdict();
	end

	function automatic logic [7:0] exp_idx(input int x);
		if (x < -40 * 256) return 8'h80;
		if (x > 102 * 256) return 8'hc7;
		return 8'(((x + 40 * 256) >>> 9) + 128);
	endfunction

	function automatic logic [7:0] exp_byte(input logic [7:0] x);
		if (x[7:6] == 2'b11) return 8'hff;
		return (x[5:3] < 3'd2) ? 8'hf8 : 8'(8'hf7 + x[5:3]);
	endfunction

	// Conversion pulse, then wait past the two-edge reload latency
	task automatic conv(input int x);
		@(posedge clk_i);
		temp <= 16'(x);
		done <= 1'b1;
		@(posedge clk_i);
		done <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask

	task automatic stop_pulse();
		@(posedge clk_i);
		stop <= 1'b1;
		@(posedge clk_i);
		stop <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	initial begin
		seed = 8;
		{cyc, stb, we, adr, dat, sel, lpw, t2w, t2r, cw, cr, done, stop, bias} = '0;
		{temp, e_sw, e_a, e_b, o_sw, o_a, o_b, dev, sl_in, sl_alm, rs_src} = '0;
		{hpw, auto_index_enable, sen, aaen, ben} = 5'h1f;
		sel = 4'h3;
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		acc(0, `TLO_IDX_INDEX, 0, 32'h00);
		acc(0, `TLO_IDX_SWING, 0, 32'h00);
		acc(0, `TLO_IDX_AUX_A, 0, 32'h00);
		acc(0, `TLO_IDX_AUX_B, 0, 32'h00);
		acc(0, `TLO_IDX_RATE, 0, 32'h00);
		acc(0, `TLO_IDX_CONFIG, 0, 32'h80);
		acc(1, 10'h08a, 32'hff, 0);
		acc(0, 10'h08a, 0, 0);
		chk(bus_adr, 8'ha2);
		// Every eight-entry byte and both clamps, random fractions of a degree
		for (k = 0; k < 11; k++) begin
			t = ((k < 9) ? 16 * k - 40 : (k == 9) ? 110 : -60) * 256 + ($random(seed) & 255);
			e_sw <= $random(seed);
			e_a <= $random(seed);
			e_b <= $random(seed);
			o_sw <= $random(seed) & 8'h7f;
			o_a <= $random(seed) & 8'h7f;
			o_b <= $random(seed) & 8'h7f;
			conv(t);
			i = exp_idx(t);
			chk(a_sw, {1'b1, i[6:0]});
			chk(a_a, {1'b1, i[6:0]});
			chk(a_pl, {2'b10, i[6:1]});
			chk(a_b, {2'b10, i[6:1]});
			chk(byt, exp_byte(i));
			chk(c_sw, {2'b0, e_sw} + {o_sw, 2'b0});
			chk(c_a, {2'b0, e_a} + {o_a, 2'b0});
			chk(c_b, {2'b0, e_b} + {o_b, 2'b0});
			acc(0, `TLO_IDX_INDEX, 0, {24'h0, i});
			acc(0, `TLO_IDX_SWING, 0, {22'h0, {2'b0, e_sw} + {o_sw, 2'b0}});
		end
		acc(1, `TLO_IDX_INDEX, 32'h55, 0);
		acc(0, `TLO_IDX_INDEX, 0, {24'h0, i});
		auto_index_enable <= 1'b0;
		acc(1, `TLO_IDX_INDEX, 32'h9a, 0);
		acc(0, `TLO_IDX_INDEX, 0, 32'h9a);
		hpw <= 1'b0;
		lpw <= 1'b1;
		acc(1, `TLO_IDX_INDEX, 32'h33, 0);
		acc(0, `TLO_IDX_INDEX, 0, 0);
		{t2r, t2w} <= 2'b11;
		acc(1, `TLO_IDX_INDEX, 32'h33, 0);
		acc(0, `TLO_IDX_INDEX, 0, 32'h33);
		conv(0);
		chk(a_sw, 8'hb3);
		// Manual codes: refused while tables drive them, applied at the stop
		acc(1, `TLO_IDX_SWING, 32'h1ff, 0);
		acc(0, `TLO_IDX_SWING, 0, {22'h0, {2'b0, e_sw} + {o_sw, 2'b0}});
		sen <= 1'b0;
		acc(1, `TLO_IDX_SWING, 32'h2a5, 0);
		acc(0, `TLO_IDX_SWING, 0, 32'h2a5);
		stop_pulse();
		chk(c_sw, 10'h2a5);
		aaen <= 1'b0;
		acc(1, `TLO_IDX_AUX_A, 32'h3c3, 0);
		acc(0, `TLO_IDX_AUX_A, 0, 0);
		cw <= 1'b1;
		acc(1, `TLO_IDX_AUX_A, 32'h3c3, 0);
		acc(0, `TLO_IDX_AUX_A, 0, 32'h3c3);
		stop_pulse();
		chk(c_a, 10'h3c3);
		{cw, cr} <= 2'b01;
		acc(0, `TLO_IDX_AUX_A, 0, 32'h3c3);
		{lpw, hpw, cw, ben} <= 4'b0100;
		acc(1, `TLO_IDX_AUX_B, 32'h155, 0);
		acc(0, `TLO_IDX_AUX_B, 0, 32'h155);
		stop_pulse();
		chk(c_b, 10'h155);
		for (k = 0; k < 10; k++) begin
			v = $random(seed);
			sl_in <= $random(seed);
			sl_alm <= $random(seed);
			rs_src <= $random(seed);
			dev <= $random(seed);
			acc(1, `TLO_IDX_CONFIG, {24'h0, v}, 0);
			acc(0, `TLO_IDX_CONFIG, 0, {24'h0, v & 8'hbc});
			repeat (6) @(posedge clk_i);
			chk(sl_out, v[7] ? (sl_in ^ v[5]) : sl_alm);
			chk(rs_out, rs_src ^ v[2]);
			chk(bus_adr, v[4] ? dev : 8'ha2);
			chk(row5, v[3]);
		end
		acc(1, `TLO_IDX_RATE, 32'hf5, 0);
		acc(0, `TLO_IDX_RATE, 0, 32'hf5);
		acc(1, `TLO_IDX_RATE, 32'h00, 0);
		bias <= 1'b1;
		@(posedge clk_i);
		bias <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk(cmp_en, 1'b0);
		q0 = qn;
		s0 = sn;
		repeat (12000) @(posedge clk_i);
		chk(cmp_en, 1'b0);
		chk(qn - q0, 30);
		chk(sn - s0, 30);
		repeat (1300) @(posedge clk_i);
		chk(cmp_en, 1'b1);
		give_verdict();
	end
endmodule
